// [hdl/oflmw_pkg.sv]
// Constants for the overflow message write register set.
// Assumes a 12-bit offset within each security space's feature frame.
package oflmw_pkg;

    localparam int unsigned OFS_W = 12;
    localparam logic [OFS_W-1:0] OFS_LABEL = 12'h8dc;
    localparam logic [OFS_W-1:0] OFS_ADDR_LOW = 12'h8e0;
    localparam logic [OFS_W-1:0] OFS_ADDR_HIGH = 12'h8e4;
    localparam logic [OFS_W-1:0] OFS_PAYLOAD = 12'h8e8;
    localparam logic [OFS_W-1:0] OFS_ATTR = 12'h8ec;
    localparam logic [OFS_W-1:0] OFS_STATUS = 12'h8f0;

    // Label layout
    localparam int unsigned LBL_PARTITION_IDENTIFIER_LSB = 0;
    localparam int unsigned LBL_PARTITION_IDENTIFIER_W = 16;
    localparam int unsigned LBL_PMG_LSB = 16;
    localparam int unsigned LBL_PMG_W = 8;
    localparam int unsigned LBL_W = 24;

    // Attribute layout
    localparam int unsigned ATTR_EN_BIT = 0;
    localparam int unsigned ATTR_MEM_LSB = 24;
    localparam int unsigned ATTR_MEM_W = 6;
    localparam logic ATTR_EN_RESET = 1'b0;

    localparam int unsigned NUM_SPACES = 4;
    localparam int unsigned SPACE_W = 2;

    typedef enum logic [1:0] {
        OFLMW_SEC = 2'h0,
        OFLMW_NONSEC = 2'h1,
        OFLMW_ROOT = 2'h2,
        OFLMW_REALM = 2'h3
    } oflmw_space_t;

    typedef enum logic {
        OFLMW_IDLE = 1'b0,
        OFLMW_ISSUE = 1'b1
    } oflmw_state_t;

endpackage

// [hdl/oflmw_space_regs.sv]
// One security space's copy of the overflow write registers.
// Assumes write strobes are already decoded and gated by the parent.
`timescale 1ns/10ps
`default_nettype none
module oflmw_space_regs
    import oflmw_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Write strobes
    input wire logic i_we_label,
    input wire logic i_we_payload,
    input wire logic i_we_addr_low,
    input wire logic i_we_addr_high,
    input wire logic i_we_attr,
    input wire logic [31:0] i_wdata,
    // Stored contents
    output logic [LBL_W-1:0] o_label,
    output logic [31:0] o_payload,
    output logic [63:0] o_addr,
    output logic [ATTR_MEM_W-1:0] o_attr_mem,
    output logic o_enable
);

    // No reset: contents are unknown until software programs them
    always_ff @(posedge i_clk_sys) begin
        if (i_we_label) begin
            o_label <= i_wdata[LBL_W-1:0];
        end
        if (i_we_payload) begin
            o_payload <= i_wdata;
        end
        if (i_we_addr_low) begin
            o_addr[31:0] <= i_wdata;
        end
        if (i_we_addr_high) begin
            o_addr[63:32] <= i_wdata;
        end
        if (i_we_attr) begin
            o_attr_mem <= i_wdata[ATTR_MEM_LSB +: ATTR_MEM_W];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_enable <= ATTR_EN_RESET;
        end else if (i_we_attr) begin
            o_enable <= i_wdata[ATTR_EN_BIT];
        end
    end

endmodule
`default_nettype wire

// [hdl/oflmw_top.sv]
// Overflow message write register set with its write issuer.
// Assumes one register access per cycle and a ready-driven write port.
//
// What this block does
// - Payload register's full 32 bits form every overflow write's data word.
// - Payload and label exist only with revision 1.1 and capability; else read zero.
// - Message writes supported only with address, attribute, payload, label all present.
// - Label holds reserved 31:24 as zero, group 23:16, partition 15:0.
// - Group and partition reset unknown; software programs both before enabling.
// - Secure copy's partition is secure-space, non-secure copy's non-secure-space.
// - Separate copies per security space; each serves only its own monitors.
// - Payload at offset 0x8e8 in each space's frame, read-write.
// - Label at offset 0x8dc in each space's frame, read-write.
// - Root and realm copies are accessible only with realm management feature.
// - Read-only status summary per space only when its capability is 1.
// - Writes only while enable is 1, suppressing wired interrupt; enable resets 0.
`timescale 1ns/10ps
`default_nettype none
module oflmw_top
    import oflmw_pkg::*;
#(
    parameter bit P_REV_1_1_FEATURE = 1'b1,
    parameter bit P_MSG_OVERFLOW_CAPABILITY = 1'b1,
    parameter bit P_STATUS_SUMMARY_CAPABILITY = 1'b1,
    parameter bit P_REALM_MGMT_FEATURE = 1'b1
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register access
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [SPACE_W-1:0] i_reg_space,
    input wire logic [OFS_W-1:0] i_reg_ofs,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Monitor overflow events and status
    input wire logic [NUM_SPACES-1:0] i_oflow_evt,
    input wire logic [NUM_SPACES*32-1:0] i_status_summary,
    output logic [NUM_SPACES-1:0] o_wired_irq,
    // Overflow message write
    output logic o_msg_valid,
    input wire logic i_msg_ready,
    output logic [63:0] o_msg_addr,
    output logic [31:0] o_msg_data,
    output logic [ATTR_MEM_W-1:0] o_msg_attr,
    output logic [LBL_PMG_W-1:0] o_msg_pmg,
    output logic [LBL_PARTITION_IDENTIFIER_W-1:0] o_msg_partition_identifier,
    output logic [SPACE_W-1:0] o_msg_space
);

    // Lowest index wins: secure spaces are served first
    // No bounded wait for the others: one write per grant, then fixed-priority arbitration again
    function automatic logic [SPACE_W-1:0] first_set(input logic [NUM_SPACES-1:0] vec);
        logic [SPACE_W-1:0] idx;
        idx = '0;
        for (int i = NUM_SPACES - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = SPACE_W'(i);
            end
        end
        return idx;
    endfunction

    // Reset leaves through two flops so all registers come out of it on one edge
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Root and realm frames answer only when the realm feature is built in
    function automatic logic space_open(input logic [SPACE_W-1:0] space);
        return (space == OFLMW_SEC) || (space == OFLMW_NONSEC) || P_REALM_MGMT_FEATURE;
    endfunction

    // Feature gating; capabilities are fixed at build time, so absent words read zero
    wire msg_regs_present = P_REV_1_1_FEATURE && P_MSG_OVERFLOW_CAPABILITY;
    wire space_ok = space_open(i_reg_space);
    wire msg_access = msg_regs_present && space_ok;

    // Offsets are decoded in full, so aliases of a register read zero
    wire hit_label = i_reg_ofs == OFS_LABEL;
    wire hit_payload = i_reg_ofs == OFS_PAYLOAD;
    wire hit_addr_low = i_reg_ofs == OFS_ADDR_LOW;
    wire hit_addr_high = i_reg_ofs == OFS_ADDR_HIGH;
    wire hit_attr = i_reg_ofs == OFS_ATTR;
    wire hit_status = i_reg_ofs == OFS_STATUS;
    wire wr_ok = i_reg_wr && msg_access;

    // Per-space copies live in the child; these arrays only gather their outputs
    logic [LBL_W-1:0] label_q [NUM_SPACES];
    logic [31:0] payload_q [NUM_SPACES];
    logic [63:0] addr_q [NUM_SPACES];
    logic [ATTR_MEM_W-1:0] attr_q [NUM_SPACES];
    logic [NUM_SPACES-1:0] enable_q;

    for (genvar s = 0; s < NUM_SPACES; s++) begin : g_space
        wire sel = wr_ok && (i_reg_space == SPACE_W'(s));
        oflmw_space_regs u_regs (
            .i_clk_sys(i_clk_sys),
            .i_rst_n(rst_sync_n),
            .i_we_label(sel && hit_label),
            .i_we_payload(sel && hit_payload),
            .i_we_addr_low(sel && hit_addr_low),
            .i_we_addr_high(sel && hit_addr_high),
            .i_we_attr(sel && hit_attr),
            .i_wdata(i_reg_wdata),
            .o_label(label_q[s]),
            .o_payload(payload_q[s]),
            .o_addr(addr_q[s]),
            .o_attr_mem(attr_q[s]),
            .o_enable(enable_q[s])
        );
    end

    // Read selection; absent or unmapped words read as zero
    wire [LBL_W-1:0] rd_label = label_q[i_reg_space];
    wire [63:0] rd_addr = addr_q[i_reg_space];
    wire [31:0] rd_attr = {2'h0, attr_q[i_reg_space], 23'h0, enable_q[i_reg_space]};
    wire [31:0] rd_status = i_status_summary[i_reg_space*32 +: 32];
    wire [31:0] rd_msg_word = hit_label ? {8'h0, rd_label} :
                              hit_payload ? payload_q[i_reg_space] :
                              hit_addr_low ? rd_addr[31:0] :
                              hit_addr_high ? rd_addr[63:32] :
                              hit_attr ? rd_attr : 32'h0;
    wire status_ok = P_STATUS_SUMMARY_CAPABILITY && space_ok && hit_status;
    wire [31:0] next_rdata = status_ok ? rd_status :
                             msg_access ? rd_msg_word : 32'h0;

    // rdata holds until the next read; rvalid alone marks a fresh word
    always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            o_reg_rdata <= 32'h0;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    // Overflow handling
    oflmw_state_t state;
    oflmw_state_t next_state;
    logic [NUM_SPACES-1:0] pend;
    wire [NUM_SPACES-1:0] msg_en_vec = msg_regs_present ? enable_q : '0;
    wire [NUM_SPACES-1:0] new_evt = i_oflow_evt & msg_en_vec;
    // Hardwired line only for spaces that are not sending writes
    wire [NUM_SPACES-1:0] wired_evt = i_oflow_evt & ~msg_en_vec;
    // Clearing an enable drops its pending write; one already on the port still completes
    wire [NUM_SPACES-1:0] live_pend = pend & msg_en_vec;
    wire [SPACE_W-1:0] pick = first_set(live_pend);
    wire grant = (state == OFLMW_IDLE) && (|live_pend);
    wire [NUM_SPACES-1:0] grant_mask = grant ? (NUM_SPACES'(1) << pick) : '0;
    // A new event in the granting cycle stays pending for another write
    wire [NUM_SPACES-1:0] next_pend = (live_pend & ~grant_mask) | new_evt;
    wire issue_next = (next_state == OFLMW_ISSUE);
    wire [LBL_W-1:0] pick_label = label_q[pick];

    // One write in flight; after each handshake the idle state arbitrates again
    always_comb begin
        next_state = state;
        unique case (state)
            OFLMW_IDLE: begin
                if (grant) begin
                    next_state = OFLMW_ISSUE;
                end
            end
            OFLMW_ISSUE: begin
                if (i_msg_ready) begin
                    next_state = OFLMW_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= OFLMW_IDLE;
            pend <= '0;
            o_wired_irq <= '0;
            o_msg_valid <= 1'b0;
        end else begin
            state <= next_state;
            pend <= next_pend;
            o_wired_irq <= wired_evt;
            o_msg_valid <= issue_next;
        end
    end

    // Write fields are latched at grant and held for the whole handshake
    // All fields come from the granted space only, so no write mixes two copies
    always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            o_msg_addr <= 64'h0;
            o_msg_data <= 32'h0;
            o_msg_attr <= '0;
            o_msg_pmg <= '0;
            o_msg_partition_identifier <= '0;
            o_msg_space <= '0;
        end else if (grant) begin
            o_msg_addr <= addr_q[pick];
            o_msg_data <= payload_q[pick];
            o_msg_attr <= attr_q[pick];
            o_msg_pmg <= pick_label[LBL_PMG_LSB +: LBL_PMG_W];
            o_msg_partition_identifier <= pick_label[LBL_PARTITION_IDENTIFIER_LSB +: LBL_PARTITION_IDENTIFIER_W];
            o_msg_space <= pick;
        end
    end

endmodule
`default_nettype wire

// [verif/oflmw_chk.sv]
// Port checker for the overflow write register set.
// Assumes binding to oflmw_top with all features present.
`timescale 1ns/10ps
`default_nettype none
module oflmw_chk
    import oflmw_pkg::*;
(
    // Clock, reset and register bus
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_reg_rd,
    input wire logic [SPACE_W-1:0] i_reg_space,
    input wire logic [OFS_W-1:0] i_reg_ofs,
    input wire logic [31:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // Overflow side
    input wire logic [NUM_SPACES-1:0] i_oflow_evt,
    input wire logic [NUM_SPACES*32-1:0] i_status_summary,
    input wire logic [NUM_SPACES-1:0] o_wired_irq,
    input wire logic o_msg_valid,
    input wire logic i_msg_ready,
    input wire logic [31:0] o_msg_data,
    input wire logic [SPACE_W-1:0] o_msg_space
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    property p_rd; i_reg_rd |=> o_reg_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_rv; o_reg_rvalid |-> $past(i_reg_rd); endproperty
    a_rv: assert property (p_rv) else $error("stray read valid");
    property p_lbl; o_reg_rvalid && $past(i_reg_ofs) == OFS_LABEL |-> o_reg_rdata[31:24] == 8'h00; endproperty
    a_lbl: assert property (p_lbl) else $error("label top byte set");
    property p_sts;
        o_reg_rvalid && $past(i_reg_ofs) == OFS_STATUS |-> o_reg_rdata == $past(i_status_summary[i_reg_space*32 +: 32]);
    endproperty
    a_sts: assert property (p_sts) else $error("status word wrong");
    property p_wired; o_wired_irq != 4'h0 |-> (o_wired_irq & ~$past(i_oflow_evt)) == 4'h0; endproperty
    a_wired: assert property (p_wired) else $error("wired irq without event");
    property p_rst; $rose(i_rst_n) |-> !o_msg_valid [*3]; endproperty
    a_rst: assert property (p_rst) else $error("write right after reset");
    property p_hold;
        o_msg_valid && !i_msg_ready |=> o_msg_valid && $stable(o_msg_data) && $stable(o_msg_space);
    endproperty
    a_hold: assert property (p_hold) else $error("write dropped or changed");
    property p_gap; o_msg_valid && i_msg_ready |=> !o_msg_valid; endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle after write");
endmodule
bind oflmw_top oflmw_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_rd(i_reg_rd),
    .i_reg_space(i_reg_space), .i_reg_ofs(i_reg_ofs), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_oflow_evt(i_oflow_evt), .i_status_summary(i_status_summary), .o_wired_irq(o_wired_irq),
    .o_msg_valid(o_msg_valid), .i_msg_ready(i_msg_ready), .o_msg_data(o_msg_data), .o_msg_space(o_msg_space));
`default_nettype wire

// [verif/oflmw_ic_model.sv]
// Interconnect model that accepts overflow writes.
// Assumes a registered valid; slow mode stalls four cycles.
`timescale 1ns/10ps
`default_nettype none
module oflmw_ic_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Write port
    input wire logic i_valid,
    input wire logic i_slow,
    input wire logic [31:0] i_data,
    input wire logic [1:0] i_space,
    output logic o_ready,
    // Last accepted write
    output logic [31:0] o_data,
    output logic [1:0] o_space,
    output logic [7:0] o_count
);
    logic [1:0] wait_cnt;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ready <= 1'b0;
            o_data <= 32'h0;
            o_space <= 2'h0;
            o_count <= 8'h0;
            wait_cnt <= 2'h0;
        end else if (i_valid && o_ready) begin
            // One word taken per handshake
            o_data <= i_data;
            o_space <= i_space;
            o_count <= o_count + 8'h1;
            o_ready <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (i_valid) begin
            wait_cnt <= wait_cnt + 2'h1;
            o_ready <= !i_slow || wait_cnt == 2'h3;
        end
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for oflmw_top with the interconnect model.
// Assumes all feature parameters at their defaults.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    import oflmw_pkg::*;
    typedef struct {logic [1:0] s; logic [11:0] o; logic [31:0] w; logic [31:0] e;} oflmw_row_t;
    logic i_clk_sys = 0, i_rst_n = 0, rd = 0, wr = 0, slow = 1, rvalid, mv, mr;
    logic [1:0] sp = 0, mspace, gspace;
    logic [11:0] ofs = 0;
    logic [31:0] wd = 0, rdata, mdata, gdata;
    logic [3:0] evt = 0, irq, seen;
    logic [63:0] maddr;
    logic [5:0] mattr;
    logic [7:0] perf_monitor_group, gcnt;
    logic [15:0] pid;
    int miscompares = 0, n_tests = 0, k;
    oflmw_row_t rows [10] = '{'{2'h0, OFS_LABEL, 32'hffffffff, 32'h00ffffff},
        '{2'h1, OFS_LABEL, 32'h12345678, 32'h00345678}, '{2'h1, OFS_PAYLOAD, 32'hcafe0001, 32'hcafe0001},
        '{2'h2, OFS_PAYLOAD, 32'ha5a5a5a5, 32'ha5a5a5a5}, '{2'h3, OFS_PAYLOAD, 32'h5a5a0003, 32'h5a5a0003},
        '{2'h1, OFS_ADDR_LOW, 32'h00001000, 32'h00001000}, '{2'h1, OFS_ATTR, 32'h25000001, 32'h25000001},
        '{2'h3, OFS_ATTR, 32'h00000001, 32'h00000001}, '{2'h1, 12'h8f4, 32'hffffffff, 32'h0},
        '{2'h2, OFS_STATUS, 32'hffffffff, 32'h00000202}};
    always #2.5 i_clk_sys = ~i_clk_sys;
    oflmw_top dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_space(sp),
        .i_reg_ofs(ofs), .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_oflow_evt(evt),
        .i_status_summary(128'h00000303_00000202_00000101_00000000), .o_wired_irq(irq), .o_msg_valid(mv),
        .i_msg_ready(mr), .o_msg_addr(maddr), .o_msg_data(mdata), .o_msg_attr(mattr), .o_msg_pmg(perf_monitor_group),
        .o_msg_partition_identifier(pid), .o_msg_space(mspace));
    oflmw_ic_model u_ic (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_valid(mv), .i_slow(slow), .i_data(mdata),
        .i_space(mspace), .o_ready(mr), .o_data(gdata), .o_space(gspace), .o_count(gcnt));
    task automatic acc(input logic w, input logic [1:0] s, input logic [11:0] o, input logic [31:0] d);
        @(posedge i_clk_sys); #1; wr = w; rd = !w; sp = s; ofs = o; wd = d;
        @(posedge i_clk_sys); #1; wr = 0; rd = 0;
    endtask
    task automatic pulse(input logic [3:0] v);
        @(posedge i_clk_sys); #1; evt = v;
        @(posedge i_clk_sys); #1; evt = 0;
    endtask
    task automatic wait_mv;
        for (k = 0; k < 10 && mv !== 1'b1; k++) begin @(posedge i_clk_sys); #1; end
        `CHK(mv, 1'b1)
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #20000; miscompares++; end_sim;
    end
    initial begin
        repeat (4) @(posedge i_clk_sys); #1; i_rst_n = 1; repeat (3) @(posedge i_clk_sys);
        foreach (rows[i]) acc(1'b1, rows[i].s, rows[i].o, rows[i].w);
        foreach (rows[i]) begin
            acc(1'b0, rows[i].s, rows[i].o, 32'h0);
            `CHK(rvalid, 1'b1)
            `CHK(rdata, rows[i].e)
        end
        $display("test registers done");
        pulse(4'b0010);
        `CHK(irq, 4'h0)
        wait_mv;
        `CHK(k, 1)
        `CHK(mdata, 32'hcafe0001)
        `CHK(pid, 16'h5678)
        `CHK(perf_monitor_group, 8'h34)
        `CHK(mattr, 6'h25)
        `CHK(maddr[31:0], 32'h00001000)
        repeat (10) @(posedge i_clk_sys); #1;
        `CHK(gcnt, 8'h1)
        $display("test slow write done");
        slow = 0; pulse(4'b1010); wait_mv;
        `CHK(mspace, 2'h1)
        repeat (12) @(posedge i_clk_sys); #1;
        `CHK(gcnt, 8'h3)
        `CHK(gspace, 2'h3)
        $display("test two spaces done");
        seen = 0; pulse(4'b0001);
        repeat (3) begin seen = seen + {3'h0, irq[0]}; @(posedge i_clk_sys); #1; end
        `CHK(seen, 4'h1)
        `CHK(gcnt, 8'h3)
        $display("test wired irq done");
        i_rst_n = 0; repeat (2) @(posedge i_clk_sys); #1; i_rst_n = 1; repeat (3) @(posedge i_clk_sys);
        acc(1'b0, 2'h1, OFS_ATTR, 32'h0);
        `CHK(rvalid, 1'b1)
        `CHK(rdata[0], 1'b0)
        $display("test reset done");
        end_sim;
    end
endmodule
`default_nettype wire
